/* File: logic/wbd_map.svh */
// Constants for the white-LED boost dimming controller.
// Assumes a 40 MHz mclk_i; included by the control module and the test bench.
`ifndef WBD_MAP_SVH
`define WBD_MAP_SVH

// Serial slave address and register offsets
`define WBD_DEV_ADDR 7'h17
`define WBD_REG_CTRL 8'h00
`define WBD_REG_MODE 8'h01

// Control register fields
`define WBD_CTRL_EN 7
`define WBD_CTRL_D0 6
`define WBD_CTRL_D4 2
`define WBD_CTRL_RESET 8'hfc

// Mode register fields
`define WBD_MODE_DIMMING_SOURCE_SELECT 6
`define WBD_MODE_SYNC 5
`define WBD_MODE_OVP_LOW 4
`define WBD_MODE_OVP_HIGH 3
`define WBD_MODE_SHORT 2
`define WBD_MODE_OPEN 1
`define WBD_MODE_OTP 0
`define WBD_MODE_RESET 8'h68

// Over-voltage points in volts
`define WBD_OVP_36V 6'h24
`define WBD_OVP_24V 6'h18
`define WBD_OVP_15V 6'h0f

// Reference curve, millivolts
`define WBD_REF_FULL_MV 8'hc8

// Timing
`define WBD_MCLK_KHZ 40000
`define WBD_PIN_LOW_MS 20
`define WBD_PIN_LOW_CYCLES (`WBD_PIN_LOW_MS * `WBD_MCLK_KHZ)
`define WBD_FILT_SHIFT 12

`endif

/* File: logic/wbd_pkg.sv */
// Types shared by the white-LED boost dimming controller.
// Constants live in wbd_map.svh.
package wbd_pkg;

  typedef struct packed {
    logic en;
    logic [4:0] code;
    logic dimming_source_select;
    logic sync;
    logic ovp_low;
    logic ovp_high;
  } wbd_ctrl_type;

  typedef struct packed {
    logic output_short_fault;
    logic led_open_fault;
    logic over_temp_fault;
  } wbd_fault_type;

  typedef enum logic [2:0] {
    SL_IDLE,
    SL_ADDR,
    SL_REG,
    SL_WDATA,
    SL_RDATA
  } wbd_slave_state_type;

endpackage

/* File: logic/wbd_boost_ctrl.sv */
// White-LED boost driver digital control: serial register slave, enable,
// dimming, protection gating and fault flags.
// Assumes pins and the oscillator are asynchronous to mclk_i.
//
// Overview of operation
// - With the rectifier select bit at 1, its default, the synchronous rectifier is driven every cycle.
// - With the rectifier select bit at 0, the rectifier is not driven and an external diode freewheels.
// - Switching runs while the enable/dimming pin is high and is suppressed while it is low.
// - A pin low phase longer than 20 ms turns the converter off with the bandgap left on; the driver keeps lows shorter.
// - Switching is enabled only when the pin is high and the enable bit is 1; the bandgap needs the enable bit but not the pin.
// - Enable bit 0 shuts down; enable bit 1 alone with the pin failing keeps the bandgap on.
// - The 5-bit reference code maps to 0, 5..38 mV by 3, 38..104 by 6 and 104..200 by 12.
// - PWM on the tied serial pins is low-pass filtered so amplitude scales with duty.
// - Switching stops while the over-voltage indication is high and resumes when it clears.
// - Control is released only above the 2.5 V indication and shut down below 2.3 V.
// - Over-temperature shuts down until the lower threshold indication clears.
// - Separate LED open, over-temperature and output short flags are set and readable.
// - Over-voltage bits pick 36 V (01, default), 24 V (10) or 15 V (00).
// - The three fault flags are read-only and reset to 0.
// - The slave answers address 0x17 and the byte after it selects the register.
// - Dimming source 1 follows the filtered pin PWM, 0 follows the reference code.
`timescale 1ns/10ps
`include "wbd_map.svh"

module wbd_boost_ctrl import wbd_pkg::*; #(
  parameter int PIN_LOW_CYCLES = `WBD_PIN_LOW_CYCLES
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Serial pins (tied together for pin PWM dimming)
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Enable and oscillator
  input wire logic enable_dimming_pin_i,
  input wire logic osc_clk_i,
  // Analog indications
  input wire logic ovp_trip_i,
  input wire logic vin_above_rise_i,
  input wire logic vin_above_fall_i,
  input wire logic temp_over_high_i,
  input wire logic temp_over_low_i,
  input wire logic output_short_i,
  // Converter control
  output logic bandgap_en_o,
  output logic converter_on_o,
  output logic switch_en_o,
  output logic sync_rect_en_o,
  output logic [7:0] fb_target_mv_o,
  output logic [5:0] ovp_point_v_o,
  output wbd_fault_type faults_o
);

  // Two-flop synchronisers
  logic [7:0] meta;
  logic [7:0] syn;
  always_ff @(posedge mclk_i) begin
    meta <= {scl_i, sda_i, enable_dimming_pin_i, osc_clk_i, ovp_trip_i,
             vin_above_rise_i, vin_above_fall_i, temp_over_high_i};
    syn <= meta;
  end
  logic scl_s, sda_s, pin_s, osc_s, ovp_s, vin_rise_s, vin_fall_s, t_high_s;
  assign {scl_s, sda_s, pin_s, osc_s, ovp_s, vin_rise_s, vin_fall_s, t_high_s} = syn;

  logic [1:0] meta2;
  logic [1:0] syn2;
  always_ff @(posedge mclk_i) begin
    meta2 <= {temp_over_low_i, output_short_i};
    syn2 <= meta2;
  end
  logic t_low_s, short_s;
  assign {t_low_s, short_s} = syn2;

  logic scl_d, sda_d, osc_d;
  always_ff @(posedge mclk_i) begin
    scl_d <= scl_s;
    sda_d <= sda_s;
    osc_d <= osc_s;
  end
  logic scl_rise, scl_fall, start_c, stop_c, cycle_start;
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_c = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_c = scl_s & scl_d & ~sda_d & sda_s;
  assign cycle_start = osc_s & ~osc_d;

  // Software registers
  wbd_ctrl_type ctrl;
  wbd_ctrl_type ctrl_act;
  wbd_fault_type faults;
  logic [7:0] ctrl_byte, mode_byte;
  assign ctrl_byte = {ctrl.en, ctrl.code[0], ctrl.code[1], ctrl.code[2], ctrl.code[3],
                      ctrl.code[4], 2'b00};
  assign mode_byte = {1'b0, ctrl.dimming_source_select, ctrl.sync, ctrl.ovp_low, ctrl.ovp_high,
                      faults.output_short_fault, faults.led_open_fault,
                      faults.over_temp_fault};

  // Serial slave
  wbd_slave_state_type state;
  logic [7:0] shreg, ptr, rd_sh;
  logic [3:0] cnt;
  logic slv_ack, mst_ack, mst_nack, wr_strobe, rd_mode_strobe;
  logic [7:0] rd_data;
  assign rd_data = (ptr == `WBD_REG_CTRL) ? ctrl_byte :
                   (ptr == `WBD_REG_MODE) ? mode_byte : 8'h00;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state <= SL_IDLE;
      shreg <= 8'h00;
      ptr <= 8'h00;
      rd_sh <= 8'h00;
      cnt <= 4'h0;
      slv_ack <= 1'b0;
      mst_ack <= 1'b0;
      mst_nack <= 1'b0;
      sda_oe_o <= 1'b0;
      wr_strobe <= 1'b0;
      rd_mode_strobe <= 1'b0;
    end else begin
      wr_strobe <= 1'b0;
      rd_mode_strobe <= 1'b0;
      // Advance only once the write has used the pointer
      if (wr_strobe) begin
        ptr <= ptr + 8'h01;
      end
      if (start_c) begin
        state <= SL_ADDR;
        cnt <= 4'h0;
        slv_ack <= 1'b0;
        mst_ack <= 1'b0;
        sda_oe_o <= 1'b0;
      end else if (stop_c) begin
        state <= SL_IDLE;
        slv_ack <= 1'b0;
        mst_ack <= 1'b0;
        sda_oe_o <= 1'b0;
      end else if (state != SL_IDLE && scl_rise) begin
        if (mst_ack) begin
          mst_nack <= sda_s;
        end else if (!slv_ack) begin
          shreg <= {shreg[6:0], sda_s};
          cnt <= cnt + 4'h1;
        end
      end else if (state != SL_IDLE && scl_fall) begin
        if (slv_ack || mst_ack) begin
          slv_ack <= 1'b0;
          mst_ack <= 1'b0;
          cnt <= 4'h0;
          sda_oe_o <= 1'b0;
          unique case (state)
            SL_ADDR: begin
              if (shreg[0]) begin
                state <= SL_RDATA;
                rd_sh <= rd_data;
                sda_oe_o <= ~rd_data[7];
                rd_mode_strobe <= (ptr == `WBD_REG_MODE);
              end else begin
                state <= SL_REG;
              end
            end
            SL_REG: state <= SL_WDATA;
            SL_WDATA: begin
              wr_strobe <= 1'b1;
            end
            SL_RDATA: begin
              if (mst_nack) begin
                state <= SL_IDLE;
              end else begin
                rd_sh <= rd_data;
                sda_oe_o <= ~rd_data[7];
                rd_mode_strobe <= (ptr == `WBD_REG_MODE);
              end
            end
            SL_IDLE: state <= SL_IDLE;
          endcase
        end else if (cnt == 4'h8) begin
          unique case (state)
            SL_ADDR: begin
              if (shreg[7:1] == `WBD_DEV_ADDR) begin
                slv_ack <= 1'b1;
                sda_oe_o <= 1'b1;
              end else begin
                state <= SL_IDLE;
              end
            end
            SL_REG: begin
              ptr <= shreg;
              slv_ack <= 1'b1;
              sda_oe_o <= 1'b1;
            end
            SL_WDATA: begin
              slv_ack <= 1'b1;
              sda_oe_o <= 1'b1;
            end
            SL_RDATA: begin
              mst_ack <= 1'b1;
              sda_oe_o <= 1'b0;
              ptr <= ptr + 8'h01;
            end
            SL_IDLE: state <= SL_IDLE;
          endcase
        end else if (state == SL_RDATA) begin
          sda_oe_o <= ~rd_sh[3'(4'h7 - cnt)];
        end
      end
    end
  end
  assign sda_o = 1'b0;

  // Register writes
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ctrl.en <= 1'(`WBD_CTRL_RESET >> `WBD_CTRL_EN);
      ctrl.code <= 5'h1f;
      ctrl.dimming_source_select <= 1'(`WBD_MODE_RESET >> `WBD_MODE_DIMMING_SOURCE_SELECT);
      ctrl.sync <= 1'(`WBD_MODE_RESET >> `WBD_MODE_SYNC);
      ctrl.ovp_low <= 1'(`WBD_MODE_RESET >> `WBD_MODE_OVP_LOW);
      ctrl.ovp_high <= 1'(`WBD_MODE_RESET >> `WBD_MODE_OVP_HIGH);
    end else if (wr_strobe && ptr == `WBD_REG_CTRL) begin
      ctrl.en <= shreg[`WBD_CTRL_EN];
      ctrl.code <= {shreg[`WBD_CTRL_D4], shreg[3], shreg[4], shreg[5], shreg[`WBD_CTRL_D0]};
    end else if (wr_strobe && ptr == `WBD_REG_MODE) begin
      ctrl.dimming_source_select <= shreg[`WBD_MODE_DIMMING_SOURCE_SELECT];
      ctrl.sync <= shreg[`WBD_MODE_SYNC];
      ctrl.ovp_low <= shreg[`WBD_MODE_OVP_LOW];
      ctrl.ovp_high <= shreg[`WBD_MODE_OVP_HIGH];
    end
  end

  // Settings in force from the next switching cycle
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ctrl_act <= '0;
    end else if (cycle_start) begin
      ctrl_act <= ctrl;
    end
  end

  // Pin low timeout
  logic [31:0] low_cnt;
  logic pin_timeout;
  always_ff @(posedge mclk_i) begin
    if (rst_i || pin_s) begin
      low_cnt <= 32'h0;
      pin_timeout <= 1'b0;
    end else if (low_cnt < 32'(PIN_LOW_CYCLES)) begin
      low_cnt <= low_cnt + 32'h1;
    end else begin
      pin_timeout <= 1'b1;
    end
  end

  // Supply and thermal state
  logic vin_ok, over_temp;
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      vin_ok <= 1'b0;
    end else if (vin_rise_s) begin
      vin_ok <= 1'b1;
    end else if (!vin_fall_s) begin
      vin_ok <= 1'b0;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      over_temp <= 1'b0;
    end else if (t_high_s) begin
      over_temp <= 1'b1;
    end else if (!t_low_s) begin
      over_temp <= 1'b0;
    end
  end

  // Fault flags: set wins over clear-on-read
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      faults <= '0;
    end else begin
      faults.over_temp_fault <= over_temp | (faults.over_temp_fault & ~rd_mode_strobe);
      faults.led_open_fault <= (ovp_s & converter_on_o) |
                               (faults.led_open_fault & ~rd_mode_strobe);
      faults.output_short_fault <= short_s |
                                   (faults.output_short_fault & ~rd_mode_strobe);
    end
  end
  assign faults_o = faults;

  // Enable and gating
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      bandgap_en_o <= 1'b0;
      converter_on_o <= 1'b0;
      switch_en_o <= 1'b0;
      sync_rect_en_o <= 1'b0;
    end else begin
      bandgap_en_o <= ctrl.en & vin_ok & ~over_temp;
      converter_on_o <= ctrl.en & vin_ok & ~over_temp & ~pin_timeout;
      switch_en_o <= ctrl.en & vin_ok & ~over_temp & pin_s & ~ovp_s;
      sync_rect_en_o <= ctrl.en & vin_ok & ~over_temp & pin_s & ~ovp_s
                        & ctrl_act.sync;
    end
  end

  // Reference curve
  function automatic logic [7:0] code_to_mv(input logic [4:0] c);
    logic [7:0] c8;
    c8 = {3'b000, c};
    if (c == 5'h00) begin
      code_to_mv = 8'h00;
    end else if (c <= 5'h0c) begin
      code_to_mv = 8'(8'h05 + 8'(8'h03 * (c8 - 8'h01)));
    end else if (c <= 5'h17) begin
      code_to_mv = 8'(8'h26 + 8'(8'h06 * (c8 - 8'h0c)));
    end else begin
      code_to_mv = 8'(8'h68 + 8'(8'h0c * (c8 - 8'h17)));
    end
  endfunction

  // Pin PWM averaging on the tied serial pins
  logic [23:0] filt;
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      filt <= 24'h0;
    end else begin
      filt <= filt - (filt >> `WBD_FILT_SHIFT) + (sda_s ? 24'h000fff : 24'h0);
    end
  end
  logic [15:0] pwm_mv;
  assign pwm_mv = 16'(`WBD_REF_FULL_MV) * {8'h00, filt[23:16]};

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      fb_target_mv_o <= 8'h00;
      ovp_point_v_o <= `WBD_OVP_36V;
    end else begin
      fb_target_mv_o <= ctrl_act.dimming_source_select ? pwm_mv[15:8] : code_to_mv(ctrl_act.code);
      unique case ({ctrl_act.ovp_high, ctrl_act.ovp_low})
        2'b01: ovp_point_v_o <= `WBD_OVP_24V;
        2'b00: ovp_point_v_o <= `WBD_OVP_15V;
        default: ovp_point_v_o <= `WBD_OVP_36V;
      endcase
    end
  end

endmodule // wbd_boost_ctrl

/* File: testbench/wbd_boost_ctrl_chk.sv */
// Checker for the boost dimming control: gating, protection and flags.
// Bound to wbd_boost_ctrl; sees its ports only.
`timescale 1ns/10ps
module wbd_boost_ctrl_chk import wbd_pkg::*; #(
  parameter int PIN_LOW_CYCLES = 200
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Pins and indications
  input wire logic enable_dimming_pin_i,
  input wire logic ovp_trip_i,
  input wire logic vin_above_fall_i,
  input wire logic temp_over_high_i,
  input wire logic output_short_i,
  // Converter control
  input wire logic bandgap_en_o,
  input wire logic converter_on_o,
  input wire logic switch_en_o,
  input wire logic sync_rect_en_o,
  input wire logic [7:0] fb_target_mv_o,
  input wire logic [5:0] ovp_point_v_o,
  input wire wbd_fault_type faults_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  int low_cnt;
  // Pin low time, saturating
  always_ff @(posedge mclk_i) begin
    if (rst_i || enable_dimming_pin_i) begin
      low_cnt <= 0;
    end else if (low_cnt < PIN_LOW_CYCLES + 8) begin
      low_cnt <= low_cnt + 1;
    end
  end
  rect_gate_a: assert property (sync_rect_en_o |-> switch_en_o)
    else $error("rectifier driven without switching");
  pin_low_a: assert property (!enable_dimming_pin_i [*8] |-> !switch_en_o)
    else $error("switching while pin low");
  pin_timeout_a: assert property (low_cnt == PIN_LOW_CYCLES + 8 |-> !converter_on_o)
    else $error("no shutdown after long pin low");
  switch_bg_a: assert property (switch_en_o |-> bandgap_en_o)
    else $error("switching without bandgap");
  ovp_stop_a: assert property (ovp_trip_i [*8] |-> !switch_en_o)
    else $error("switching during over-voltage");
  input_undervoltage_lockout_off_a: assert property (!vin_above_fall_i [*8] |-> !bandgap_en_o)
    else $error("bandgap on below input threshold");
  otp_off_a: assert property (temp_over_high_i [*8] |-> !bandgap_en_o && faults_o.over_temp_fault)
    else $error("over-temperature not handled");
  short_flag_a: assert property (output_short_i [*8] |-> faults_o.output_short_fault)
    else $error("short flag not set");
  ref_range_a: assert property (fb_target_mv_o <= 8'hc8)
    else $error("feedback target above full scale");
  ovp_set_a: assert property (ovp_point_v_o inside {6'h24, 6'h18, 6'h0f})
    else $error("illegal over-voltage point");
  reset_flags_a: assert property (disable iff (1'b0) rst_i |=> faults_o == 3'h0)
    else $error("fault flags not cleared by reset");
  cover property (low_cnt == PIN_LOW_CYCLES + 8);
  cover property (switch_en_o && !sync_rect_en_o);
  cover property ($rose(faults_o.led_open_fault));
endmodule // wbd_boost_ctrl_chk

bind wbd_boost_ctrl wbd_boost_ctrl_chk #(.PIN_LOW_CYCLES(PIN_LOW_CYCLES)) chk_u (
  .mclk_i(mclk_i),
  .rst_i(rst_i),
  .enable_dimming_pin_i(enable_dimming_pin_i),
  .ovp_trip_i(ovp_trip_i),
  .vin_above_fall_i(vin_above_fall_i),
  .temp_over_high_i(temp_over_high_i),
  .output_short_i(output_short_i),
  .bandgap_en_o(bandgap_en_o),
  .converter_on_o(converter_on_o),
  .switch_en_o(switch_en_o),
  .sync_rect_en_o(sync_rect_en_o),
  .fb_target_mv_o(fb_target_mv_o),
  .ovp_point_v_o(ovp_point_v_o),
  .faults_o(faults_o)
);

/* File: testbench/wbd_host_model.sv */
// Host controller model: serial master writing and reading device registers.
// Assumes a pull-up on the data wire; sda_o high releases it.
`timescale 1ns/10ps
module wbd_host_model (
  // Bus clock
  input wire logic clk_i,
  // Data wire as resolved on the bus
  input wire logic sda_line_i,
  // Driven pins
  output logic scl_o,
  output logic sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // One quarter bit, 650 ns
  task automatic step(input logic c, input logic d);
    scl_o <= c;
    sda_o <= d;
    repeat (26) @(posedge clk_i);
  endtask
  // Data changes only while the clock is low
  task automatic bit_io(input logic b, output logic rd);
    step(1'b0, sda_o);
    step(1'b0, b);
    step(1'b1, b);
    rd = sda_line_i;
    step(1'b1, b);
  endtask
  task automatic byte_out(input logic [7:0] v, output logic ack);
    logic rd;
    for (int i = 7; i >= 0; i--) begin
      bit_io(v[i], rd);
    end
    bit_io(1'b1, rd);
    ack = ~rd;
  endtask
  // Start, address with write bit, register, data, stop
  task automatic write_reg(input logic [6:0] a, input logic [7:0] r, input logic [7:0] d,
                           output logic ack);
    logic a2;
    step(1'b1, 1'b0);
    byte_out({a, 1'b0}, ack);
    if (ack) begin
      byte_out(r, a2);
      byte_out(d, a2);
    end
    step(1'b0, sda_o);
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask
  // Start, address with write bit, register, repeated start, read one byte, nack, stop
  task automatic read_reg(input logic [6:0] a, input logic [7:0] r, output logic [7:0] d,
                          output logic ack);
    logic a2;
    logic rd;
    d = 8'h00;
    step(1'b1, 1'b0);
    byte_out({a, 1'b0}, ack);
    byte_out(r, a2);
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    byte_out({a, 1'b1}, a2);
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, rd);
      d[i] = rd;
    end
    bit_io(1'b1, rd);
    step(1'b0, sda_o);
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask
endmodule // wbd_host_model

/* File: testbench/wbd_boost_ctrl_test.sv */
// Self-checking bench for the boost dimming control.
// Uses wbd_host_model on the serial pins; checker comes in by bind.
`timescale 1ns/10ps
`include "wbd_map.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module wbd_boost_ctrl_test import wbd_pkg::*; ;
  localparam int PLC = 200;
  logic mclk = 0, rst = 1, osc = 0, pin = 1, ovp = 0, vr = 0, vf = 1, th = 0, tl = 0, sh = 0;
  logic scl, sda_h, sda_oe, bg, con, sw, sr, ack;
  logic [7:0] fb;
  logic [5:0] ovpv;
  wbd_fault_type flt;
  int failures = 0;
  int total_checks = 0;
  wire sda_line = sda_h & ~sda_oe;
  always #12.5 mclk = ~mclk;
  always #100 osc = ~osc;
  wbd_host_model host_u (.clk_i(mclk), .sda_line_i(sda_line), .scl_o(scl), .sda_o(sda_h));
  wbd_boost_ctrl #(.PIN_LOW_CYCLES(PLC)) dut_u (.mclk_i(mclk), .rst_i(rst), .scl_i(scl),
    .sda_i(sda_line), .sda_o(), .sda_oe_o(sda_oe), .enable_dimming_pin_i(pin), .osc_clk_i(osc),
    .ovp_trip_i(ovp), .vin_above_rise_i(vr), .vin_above_fall_i(vf), .temp_over_high_i(th),
    .temp_over_low_i(tl), .output_short_i(sh), .bandgap_en_o(bg), .converter_on_o(con),
    .switch_en_o(sw), .sync_rect_en_o(sr), .fb_target_mv_o(fb), .ovp_point_v_o(ovpv),
    .faults_o(flt));
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] r, input logic [7:0] d);
    host_u.write_reg(`WBD_DEV_ADDR, r, d, ack);
    `CHK(ack, 1'b1)
    cyc(30);
  endtask
  function automatic logic [7:0] ref_mv(input int c);
    if (c == 0) return 8'h00;
    if (c <= 12) return 8'(5 + 3 * (c - 1));
    if (c <= 23) return 8'(38 + 6 * (c - 12));
    return 8'(104 + 12 * (c - 23));
  endfunction
  task automatic t_start;
    `CHK(fb >= 8'hb4, 1'b1)
    `CHK({ovpv, flt, bg, con, sw, sr}, {6'h24, 3'h0, 4'hf})
  endtask
  task automatic t_ovp;
    logic [7:0] m[4] = '{8'h28, 8'h30, 8'h20, 8'h08};
    logic [5:0] v[4] = '{6'h24, 6'h18, 6'h0f, 6'h24};
    for (int i = 0; i < 4; i++) begin
      wr(`WBD_REG_MODE, m[i]);
      `CHK({ovpv, sw, sr}, {v[i], 1'b1, m[i][5]})
    end
  endtask
  task automatic t_ref;
    int codes[7] = '{0, 1, 12, 13, 23, 24, 31};
    logic [4:0] c;
    wr(`WBD_REG_MODE, 8'h28);
    foreach (codes[i]) begin
      c = 5'(codes[i]);
      wr(`WBD_REG_CTRL, {1'b1, c[0], c[1], c[2], c[3], c[4], 2'b00});
      `CHK(fb, ref_mv(codes[i]))
    end
  endtask
  task automatic t_pin;
    pin <= 1'b0;
    cyc(10);
    `CHK({bg, con, sw}, 3'b110)
    cyc(PLC);
    `CHK({bg, con, sw}, 3'b100)
    pin <= 1'b1;
    cyc(10);
    `CHK({con, sw}, 2'b11)
  endtask
  task automatic t_en;
    wr(`WBD_REG_CTRL, 8'h7c);
    `CHK({bg, sw}, 2'b00)
    wr(`WBD_REG_CTRL, 8'hfc);
    host_u.write_reg(7'h16, `WBD_REG_CTRL, 8'h00, ack);
    cyc(30);
    `CHK({ack, bg, sw, fb}, {3'b011, 8'hc8})
  endtask
  task automatic t_prot;
    ovp <= 1'b1;
    cyc(10);
    `CHK({sw, flt.led_open_fault}, 2'b01)
    ovp <= 1'b0;
    vr <= 1'b0;
    vf <= 1'b0;
    cyc(10);
    `CHK({sw, bg}, 2'b00)
    vf <= 1'b1;
    cyc(10);
    `CHK(bg, 1'b0)
    vr <= 1'b1;
    cyc(10);
    `CHK({bg, sw}, 2'b11)
    th <= 1'b1;
    tl <= 1'b1;
    cyc(10);
    `CHK({bg, flt.over_temp_fault}, 2'b01)
    th <= 1'b0;
    cyc(10);
    `CHK(bg, 1'b0)
    tl <= 1'b0;
    sh <= 1'b1;
    cyc(10);
    `CHK({bg, flt.output_short_fault}, 2'b11)
  endtask
  task automatic t_read;
    logic [7:0] d;
    host_u.read_reg(`WBD_DEV_ADDR, `WBD_REG_MODE, d, ack);
    cyc(30);
    `CHK({ack, d, flt}, {1'b1, 8'h2f, 3'b100})
    host_u.read_reg(`WBD_DEV_ADDR, `WBD_REG_CTRL, d, ack);
    cyc(30);
    `CHK({ack, d}, {1'b1, 8'hfc})
  endtask
  task automatic print_verdict;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    cyc(20);
    rst <= 1'b0;
    vr <= 1'b1;
    cyc(15000);
    t_start;
    t_ovp;
    t_ref;
    t_pin;
    t_en;
    t_prot;
    t_read;
    print_verdict;
  end
  initial begin
    cyc(90000);
    failures++;
    print_verdict;
  end
endmodule // wbd_boost_ctrl_test
